/* src/strs_drv.sv */
`timescale 1ns/10ps
`default_nettype none

module strs_drv
	import strs_pkg::*;
#(
	parameter int P_WAKE_CYC = WAKE_CYC
) (
	input wire logic I_CLK, // 250 MHz clock
	input wire logic I_SRST, // Power-on reset, active high
	strs_if.drv LINK, // Pins from the step controller
	output logic O_BRIDGE_ON, // Both bridges driven
	output logic O_CH1_NEG, // Channel 1 current direction
	output logic [MAG_W-1:0] O_CH1_MAG, // Channel 1 current target
	output logic O_CH2_NEG, // Channel 2 current direction
	output logic [MAG_W-1:0] O_CH2_MAG, // Channel 2 current target
	output logic [POS_W-1:0] O_POS, // Translator position
	output logic O_STANDBY, // Standby state
	output logic O_WAKING // Wake-up delay running
);

	localparam int CNT_W = $clog2(P_WAKE_CYC + 1);
	localparam logic [CNT_W-1:0] WAKE_LAST =
		CNT_W'(P_WAKE_CYC - SYNC_LAT - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;

	typedef struct packed {
		logic ps_s1;
		logic ps_s2;
		logic clk_s1;
		logic clk_s2;
		logic clk_s3;
		logic en_s1;
		logic en_s2;
		logic dir_s1;
		logic dir_s2;
		logic [1:0] res_s1;
		logic [1:0] res_s2;
		strs_dstate_t fsm;
		logic [CNT_W-1:0] wake_cnt;
		logic [POS_W-1:0] pos;
		logic bridge_on;
		logic ch1_neg;
		logic [MAG_W-1:0] ch1_mag;
		logic ch2_neg;
		logic [MAG_W-1:0] ch2_mag;
	} strs_drv_st_t;

	localparam strs_drv_st_t ST_RST = '{
		ps_s1: 1'b0,
		ps_s2: 1'b0,
		clk_s1: 1'b0,
		clk_s2: 1'b0,
		clk_s3: 1'b0,
		en_s1: 1'b0,
		en_s2: 1'b0,
		dir_s1: 1'b0,
		dir_s2: 1'b0,
		res_s1: 2'h0,
		res_s2: 2'h0,
		fsm: DS_STANDBY,
		wake_cnt: CNT_ZERO,
		pos: POS_RST,
		bridge_on: 1'b0,
		ch1_neg: 1'b0,
		ch1_mag: 8'h00,
		ch2_neg: 1'b0,
		ch2_mag: 8'h00
	};

	strs_drv_st_t st_reg;
	strs_drv_st_t st_next;
	logic step_edge;
	logic [POS_W-1:0] angle;
	logic [MAG_W:0] ch1_val;
	logic [MAG_W:0] ch2_val;

	// Sign and magnitude of the sine at a 64-point angle.
	function automatic logic [MAG_W:0] sin_lookup(
		input logic [POS_W-1:0] ang
	);
		logic [4:0] idx;
		if (ang[4]) begin
			idx = QUARTER - {1'b0, ang[3:0]};
		end else begin
			idx = {1'b0, ang[3:0]};
		end
		return {ang[5], SIN_Q[idx]};
	endfunction

	// Distance moved by one accepted step in each resolution.
	function automatic logic [POS_W-1:0] step_size(
		input logic [1:0] res
	);
		logic [POS_W-1:0] inc;
		case (strs_res_t'(res))
			RES_FULL: inc = INC_FULL;
			RES_HALF: inc = INC_HALF;
			RES_EIGHTH: inc = INC_EIGHTH;
			default: inc = INC_SIXTEENTH;
		endcase
		return inc;
	endfunction

	always_comb begin
		st_next = st_reg;

		// Every pin passes two flops before the logic looks at it; enable and resolution feed the outputs after one.
		st_next.ps_s1 = LINK.power_save_n;
		st_next.ps_s2 = st_reg.ps_s1;
		st_next.clk_s1 = LINK.step_clk;
		st_next.clk_s2 = st_reg.clk_s1;
		st_next.clk_s3 = st_reg.clk_s2;
		st_next.en_s1 = LINK.drive_enable;
		st_next.en_s2 = st_reg.en_s1;
		st_next.dir_s1 = LINK.rotation_direction;
		st_next.dir_s2 = st_reg.dir_s1;
		st_next.res_s1 = {LINK.step_res_sel1, LINK.step_res_sel0};
		st_next.res_s2 = st_reg.res_s1;

		step_edge = st_reg.clk_s2 & ~st_reg.clk_s3;

		case (st_reg.fsm)
			DS_STANDBY: begin
				// Leaving reset with power-save high also passes here.
				if (st_reg.ps_s2) begin
					st_next.fsm = DS_WAKE;
					st_next.wake_cnt = CNT_ZERO;
				end
			end
			DS_WAKE: begin
				// Step edges are not looked at while waking.
				if (st_reg.wake_cnt == WAKE_LAST) begin
					st_next.fsm = DS_ACTIVE;
				end else begin
					st_next.wake_cnt = st_reg.wake_cnt + 1'b1;
				end
			end
			DS_ACTIVE: begin
				// A disabled driver does not count steps either.
				if (step_edge && st_reg.en_s2) begin
					if (st_reg.dir_s2) begin
						st_next.pos = st_reg.pos
							+ step_size(st_reg.res_s2);
					end else begin
						st_next.pos = st_reg.pos
							- step_size(st_reg.res_s2);
					end
				end
			end
			default: begin
				st_next.fsm = DS_STANDBY;
			end
		endcase

		// Power-save low overrides everything and restarts the position.
		if (!st_reg.ps_s2) begin
			st_next.fsm = DS_STANDBY;
			st_next.pos = POS_RST;
			st_next.wake_cnt = CNT_ZERO;
		end

		// Full step sits between the axes, so both coils carry current.
		if (strs_res_t'(st_next.res_s2) == RES_FULL) begin
			angle = {st_next.pos[5:4], FULL_OFS};
		end else begin
			angle = st_next.pos;
		end
		ch1_val = sin_lookup(angle + POS_W'(QUARTER));
		ch2_val = sin_lookup(angle);

		st_next.bridge_on = (st_next.fsm == DS_ACTIVE)
			&& st_next.en_s2;
		if (st_next.bridge_on) begin
			st_next.ch1_neg = ch1_val[MAG_W];
			st_next.ch1_mag = ch1_val[MAG_W-1:0];
			st_next.ch2_neg = ch2_val[MAG_W];
			st_next.ch2_mag = ch2_val[MAG_W-1:0];
		end else begin
			st_next.ch1_neg = 1'b0;
			st_next.ch1_mag = 8'h00;
			st_next.ch2_neg = 1'b0;
			st_next.ch2_mag = 8'h00;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign O_BRIDGE_ON = st_reg.bridge_on;
	assign O_CH1_NEG = st_reg.ch1_neg;
	assign O_CH1_MAG = st_reg.ch1_mag;
	assign O_CH2_NEG = st_reg.ch2_neg;
	assign O_CH2_MAG = st_reg.ch2_mag;
	assign O_POS = st_reg.pos;
	assign O_STANDBY = (st_reg.fsm == DS_STANDBY);
	assign O_WAKING = (st_reg.fsm == DS_WAKE);

endmodule // strs_drv
`default_nettype wire

/* src/strs_pkg.sv */
`default_nettype none
package strs_pkg;

	localparam int CLK_PERIOD_NS = 4;

	// Timing figures in their own units, then in clock cycles.
	localparam int WAKE_US = 40;
	localparam int PS_LOW_US = 20;
	localparam int STEP_HALF_US = 2;
	localparam int SETUP_US = 1;
	localparam int WAKE_CYC = (WAKE_US * 1000) / CLK_PERIOD_NS;
	localparam int PS_LOW_CYC =
		(PS_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_HALF_CYC =
		(STEP_HALF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC =
		(SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Two synchroniser stages plus the state change into wake-up.
	localparam int SYNC_LAT = 3;

	localparam int POS_W = 6;
	localparam int MAG_W = 8;
	localparam logic [4:0] QUARTER = 5'h10;
	localparam logic [POS_W-1:0] POS_RST = 6'h00;
	localparam logic [3:0] FULL_OFS = 4'h8;

	// Quarter sine, 17 points in sixteenth-step units, full scale FF.
	localparam logic [16:0][MAG_W-1:0] SIN_Q = {
		8'hFF, 8'hFE, 8'hFA, 8'hF4, 8'hEC, 8'hE1, 8'hD4, 8'hC5,
		8'hB4, 8'hA2, 8'h8E, 8'h78, 8'h62, 8'h4A, 8'h32, 8'h19, 8'h00
	};

	typedef enum logic [1:0] {
		RES_FULL = 2'b00,
		RES_HALF = 2'b01,
		RES_EIGHTH = 2'b10,
		RES_SIXTEENTH = 2'b11
	} strs_res_t;

	localparam logic [POS_W-1:0] INC_FULL = 6'h10;
	localparam logic [POS_W-1:0] INC_HALF = 6'h08;
	localparam logic [POS_W-1:0] INC_EIGHTH = 6'h02;
	localparam logic [POS_W-1:0] INC_SIXTEENTH = 6'h01;

	typedef enum logic [1:0] {
		DS_STANDBY = 2'b00,
		DS_WAKE = 2'b01,
		DS_ACTIVE = 2'b10
	} strs_dstate_t;

	typedef enum logic [2:0] {
		CS_PS_LOW = 3'b000,
		CS_WAKE = 3'b001,
		CS_IDLE = 3'b010,
		CS_SETUP = 3'b011,
		CS_HIGH = 3'b100,
		CS_LOW = 3'b101
	} strs_cstate_t;

	// Controller register map.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STEPS = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_RESET = 8'h0C;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_EN_BIT = 1;
	localparam int CTRL_DIR_BIT = 2;
	localparam int CTRL_RES_LSB = 3;
	localparam int CTRL_W = 5;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam int STEPS_W = 16;

endpackage
`default_nettype wire

/* src/strs_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface strs_if;
	logic step_clk;
	logic power_save_n;
	logic step_res_sel0;
	logic step_res_sel1;
	logic rotation_direction;
	logic drive_enable;

	modport ctl (
		output step_clk,
		output power_save_n,
		output step_res_sel0,
		output step_res_sel1,
		output rotation_direction,
		output drive_enable
	);

	modport drv (
		input step_clk,
		input power_save_n,
		input step_res_sel0,
		input step_res_sel1,
		input rotation_direction,
		input drive_enable
	);
endinterface
`default_nettype wire

/* src/strs_ctl.sv */
`timescale 1ns/10ps
`default_nettype none
module strs_ctl
	import strs_pkg::*;
#(
	parameter int P_PS_LOW_CYC = PS_LOW_CYC,
	parameter int P_WAKE_CYC = WAKE_CYC
) (
	input wire logic I_CLK, // 250 MHz clock
	input wire logic I_SRST, // Synchronous reset, active high
	input wire logic [7:0] I_ADDR, // Register byte address
	input wire logic [31:0] I_WDATA, // Write data
	input wire logic I_WR, // Write strobe
	input wire logic I_RD, // Read strobe
	output logic [31:0] O_RDATA, // Read data, cycle after I_RD
	strs_if.ctl LINK // Pins to the driver
);

	// The timer also paces setup and step phases, so it must hold them.
	localparam int TMR_W = $clog2(P_WAKE_CYC + P_PS_LOW_CYC
		+ STEP_HALF_CYC + SETUP_CYC + 1);
	localparam logic [TMR_W-1:0] TMR_ZERO = '0;
	localparam logic [TMR_W-1:0] PS_LOW_LAST = TMR_W'(P_PS_LOW_CYC - 1);
	localparam logic [TMR_W-1:0] WAKE_LAST = TMR_W'(P_WAKE_CYC - 1);
	localparam logic [TMR_W-1:0] SETUP_LAST = TMR_W'(SETUP_CYC - 1);
	localparam logic [TMR_W-1:0] HALF_LAST = TMR_W'(STEP_HALF_CYC - 1);

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [STEPS_W-1:0] steps;
		logic rst_req;
		strs_cstate_t fsm;
		logic [TMR_W-1:0] tmr;
		logic ps_out;
		logic clk_out;
		logic en_out;
		logic dir_out;
		logic [1:0] res_out;
		logic [31:0] rdata;
	} strs_ctl_st_t;

	strs_ctl_st_t st_reg;
	strs_ctl_st_t st_next;
	logic run;
	logic tmr_done;
	logic wr_reset;

	always_comb begin
		st_next = st_reg;
		st_next.rdata = 32'h0000_0000;
		wr_reset = 1'b0;

		if (I_WR) begin
			if (I_ADDR == REG_CTRL) begin
				st_next.ctrl = I_WDATA[CTRL_W-1:0];
			end else if (I_ADDR == REG_STEPS) begin
				st_next.steps = I_WDATA[STEPS_W-1:0];
			end else if (I_ADDR == REG_RESET) begin
				wr_reset = I_WDATA[0];
			end
		end
		if (I_RD) begin
			if (I_ADDR == REG_CTRL) begin
				st_next.rdata = {27'h0, st_reg.ctrl};
			end else if (I_ADDR == REG_STEPS) begin
				st_next.rdata = {16'h0, st_reg.steps};
			end else if (I_ADDR == REG_STATUS) begin
				st_next.rdata = {26'h0, st_reg.rst_req, st_reg.ps_out,
					(st_reg.steps != 16'h0000), st_reg.fsm};
			end
		end

		run = st_reg.ctrl[CTRL_RUN_BIT];
		tmr_done = 1'b0;
		st_next.tmr = st_reg.tmr + 1'b1;

		// Mode pins move only while the step clock is low and no edge
		// is closer than the setup time.
		if (st_reg.fsm == CS_PS_LOW || st_reg.fsm == CS_WAKE
			|| st_reg.fsm == CS_IDLE) begin
			st_next.en_out = st_reg.ctrl[CTRL_EN_BIT];
			st_next.dir_out = st_reg.ctrl[CTRL_DIR_BIT];
			st_next.res_out = st_reg.ctrl[CTRL_RES_LSB +: 2];
		end

		case (st_reg.fsm)
			CS_PS_LOW: begin
				tmr_done = (st_reg.tmr >= PS_LOW_LAST);
				if (tmr_done) begin
					st_next.tmr = st_reg.tmr;
				end
				if (tmr_done && run && !st_reg.rst_req) begin
					st_next.fsm = CS_WAKE;
					st_next.ps_out = 1'b1;
					st_next.tmr = TMR_ZERO;
				end
			end
			CS_WAKE: begin
				if (st_reg.tmr == WAKE_LAST) begin
					st_next.fsm = CS_IDLE;
				end
			end
			CS_IDLE: begin
				if (st_reg.steps != 16'h0000) begin
					st_next.fsm = CS_SETUP;
					st_next.tmr = TMR_ZERO;
				end
			end
			CS_SETUP: begin
				if (st_reg.tmr == SETUP_LAST) begin
					st_next.fsm = CS_HIGH;
					st_next.clk_out = 1'b1;
					st_next.tmr = TMR_ZERO;
					st_next.steps = st_reg.steps - 1'b1;
					if (I_WR && I_ADDR == REG_STEPS) begin
						st_next.steps = I_WDATA[STEPS_W-1:0];
					end
				end
			end
			CS_HIGH: begin
				if (st_reg.tmr == HALF_LAST) begin
					st_next.fsm = CS_LOW;
					st_next.clk_out = 1'b0;
					st_next.tmr = TMR_ZERO;
				end
			end
			CS_LOW: begin
				if (st_reg.tmr == HALF_LAST) begin
					st_next.fsm = CS_IDLE;
				end
			end
			default: begin
				st_next.fsm = CS_PS_LOW;
			end
		endcase

		// A reset request consumed now is not lost if another arrives.
		// A high step phase runs to its end first, so a stop or a reset
		// never cuts the pulse below its minimum width.
		if (st_reg.rst_req && st_reg.fsm != CS_HIGH) begin
			st_next.rst_req = 1'b0;
		end
		if (st_reg.fsm != CS_PS_LOW && st_reg.fsm != CS_HIGH
			&& (!run || st_reg.rst_req)) begin
			st_next.fsm = CS_PS_LOW;
			st_next.ps_out = 1'b0;
			st_next.clk_out = 1'b0;
			st_next.tmr = TMR_ZERO;
		end else if (st_reg.fsm == CS_PS_LOW && st_reg.rst_req) begin
			st_next.tmr = TMR_ZERO;
		end
		if (wr_reset) begin
			st_next.rst_req = 1'b1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			st_reg <= '{ctrl: CTRL_RST, steps: 16'h0000, rst_req: 1'b0,
				fsm: CS_PS_LOW, tmr: TMR_ZERO, ps_out: 1'b0,
				clk_out: 1'b0, en_out: 1'b0, dir_out: 1'b0,
				res_out: 2'h0, rdata: 32'h0000_0000};
		end else begin
			st_reg <= st_next;
		end
	end

	assign O_RDATA = st_reg.rdata;
	assign LINK.step_clk = st_reg.clk_out;
	assign LINK.power_save_n = st_reg.ps_out;
	assign LINK.drive_enable = st_reg.en_out;
	assign LINK.rotation_direction = st_reg.dir_out;
	assign LINK.step_res_sel0 = st_reg.res_out[0];
	assign LINK.step_res_sel1 = st_reg.res_out[1];

endmodule // strs_ctl
`default_nettype wire

/* sim/strs_props.sv */
`timescale 1ns/10ps
`default_nettype none
module strs_props
	import strs_pkg::*;
#(
	parameter int P_WAKE_CYC = WAKE_CYC,
	parameter int P_PS_LOW_CYC = PS_LOW_CYC
) (
	input wire logic I_CLK, // Clock
	input wire logic I_SRST, // Power-on reset
	input wire logic step_clk, // Step clock pin
	input wire logic power_save_n, // Power-save pin
	input wire logic drive_enable, // Enable pin
	input wire logic O_BRIDGE_ON, // Bridges driven
	input wire logic [POS_W-1:0] O_POS, // Translator position
	input wire logic O_STANDBY, // Standby state
	input wire logic O_WAKING // Wake-up running
);
	// Margin of a few edges covers the pin synchronisers.
	localparam int WAKE_MAX = P_WAKE_CYC + 8;
	logic clk_prev;
	logic [3:0] since_rise;
	int phase_cnt;
	int low_cnt;
	int high_cnt;
	int wake_wait;

	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_SRST);

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			clk_prev <= 1'b0;
			since_rise <= 4'hF;
			// The pin has been low since power-up, which counts as long.
			phase_cnt <= STEP_HALF_CYC;
			low_cnt <= 0;
			high_cnt <= 0;
			wake_wait <= 0;
		end else begin
			clk_prev <= step_clk;
			if (step_clk && !clk_prev)
				since_rise <= 4'h0;
			else if (since_rise != 4'hF)
				since_rise <= since_rise + 4'h1;
			phase_cnt <= (step_clk != clk_prev) ? 1 : phase_cnt + 1;
			low_cnt <= power_save_n ? 0 : low_cnt + 1;
			high_cnt <= power_save_n ? high_cnt + 1 : 0;
			wake_wait <= (power_save_n && drive_enable && !O_BRIDGE_ON)
				? wake_wait + 1 : 0;
		end
	end

	ps_fall_clear_a: assert property ($fell(power_save_n) |-> ##[1:4]
		(O_STANDBY && O_POS == POS_RST && !O_BRIDGE_ON))
		else $error("position or bridges not cleared by power-save low");
	standby_open_a: assert property (O_STANDBY |-> !O_BRIDGE_ON)
		else $error("bridges driven in standby");
	wake_pos_a: assert property (O_WAKING |-> O_POS == POS_RST)
		else $error("position moved during wake-up");
	// A counter keeps the bound cheap for the full-length wake-up delay.
	wake_bound_a: assert property (wake_wait <= WAKE_MAX)
		else $error("bridges late after power-save rise");
	reset_init_a: assert property ($fell(I_SRST) |-> O_STANDBY
		&& O_POS == POS_RST && !O_BRIDGE_ON)
		else $error("not initialised after power-on reset");
	step_on_rise_a: assert property ($changed(O_POS) && !O_STANDBY
		|-> since_rise inside {[4'h1:4'h6]})
		else $error("position moved without a step edge");
	ps_low_width_a: assert property ($rose(power_save_n)
		|-> low_cnt >= P_PS_LOW_CYC)
		else $error("power-save low pulse too short");
	step_phase_a: assert property ($changed(step_clk)
		|-> phase_cnt >= STEP_HALF_CYC)
		else $error("step clock phase too short");
	step_after_wake_a: assert property ($rose(step_clk)
		|-> high_cnt >= P_WAKE_CYC)
		else $error("step edge inside wake-up delay");

	cover property ($rose(step_clk) && O_BRIDGE_ON);
	cover property ($fell(power_save_n) && O_BRIDGE_ON);
	cover property ($fell(O_WAKING) && O_BRIDGE_ON);
endmodule // strs_props
`default_nettype wire

/* sim/strs_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin \
	checked++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("MISMATCH %s exp %0h got %0h", n, e, g); \
	end \
end
module strs_tb_top;
	import strs_pkg::*;
	logic I_CLK = 1'b0;
	logic I_SRST = 1'b1;
	logic I_WR = 1'b0;
	logic I_RD = 1'b0;
	logic [7:0] I_ADDR = 8'h00;
	logic [31:0] I_WDATA = 32'h0;
	logic [31:0] O_RDATA;
	logic [31:0] rdat;
	logic O_BRIDGE_ON, O_CH1_NEG, O_CH2_NEG, O_STANDBY, O_WAKING;
	logic seen_wake = 1'b0;
	logic [MAG_W-1:0] O_CH1_MAG, O_CH2_MAG;
	logic [POS_W-1:0] O_POS, ang;
	logic [POS_W-1:0] pos = 6'h00;
	logic [POS_W-1:0] incs [4] =
		'{INC_FULL, INC_HALF, INC_EIGHTH, INC_SIXTEENTH};
	logic [8:0] e1, e2;
	int miscompares = 0;
	int checked = 0;
	int cyc = 0;

	strs_if link();
	strs_ctl #(.P_PS_LOW_CYC(20), .P_WAKE_CYC(40)) i_strs_ctl (
		.I_CLK(I_CLK), .I_SRST(I_SRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
		.I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .LINK(link));
	strs_drv #(.P_WAKE_CYC(40)) i_strs_drv (
		.I_CLK(I_CLK), .I_SRST(I_SRST), .LINK(link),
		.O_BRIDGE_ON(O_BRIDGE_ON), .O_CH1_NEG(O_CH1_NEG),
		.O_CH1_MAG(O_CH1_MAG), .O_CH2_NEG(O_CH2_NEG), .O_CH2_MAG(O_CH2_MAG),
		.O_POS(O_POS), .O_STANDBY(O_STANDBY), .O_WAKING(O_WAKING));
	strs_props #(.P_WAKE_CYC(40), .P_PS_LOW_CYC(20)) i_strs_props (
		.I_CLK(I_CLK), .I_SRST(I_SRST), .step_clk(link.step_clk),
		.power_save_n(link.power_save_n), .drive_enable(link.drive_enable),
		.O_BRIDGE_ON(O_BRIDGE_ON), .O_POS(O_POS), .O_STANDBY(O_STANDBY),
		.O_WAKING(O_WAKING));

	initial begin
		forever #2 I_CLK = ~I_CLK;
	end

	always @(posedge I_CLK) begin
		cyc++;
		if (O_WAKING === 1'b1)
			seen_wake = 1'b1;
		if (cyc == 30000) begin
			miscompares++;
			wrap_up();
		end
	end

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_WDATA <= d;
		I_WR <= 1'b1;
		@(posedge I_CLK);
		I_WR <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		@(negedge I_CLK);
		rdat = O_RDATA;
	endtask

	// Polls until the controller is idle with no steps left.
	task wait_idle;
		for (int n = 0; n < 1000; n++) begin
			rd(REG_STATUS);
			if (rdat[2:0] === 3'h2 && rdat[3] === 1'b0)
				break;
		end
		repeat (10) @(negedge I_CLK);
	endtask

	function automatic logic [8:0] cur(input logic [5:0] a);
		int q;
		q = a[4] ? 16 - a[3:0] : a[3:0];
		return {a[5], SIN_Q[q]};
	endfunction

	task chk_drv(input logic on, input logic full);
		ang = full ? {pos[5:4], 4'h8} : pos;
		e1 = on ? cur(ang + 6'h10) : 9'h0;
		e2 = on ? cur(ang) : 9'h0;
		`CHK("pos", pos, O_POS)
		`CHK("bridge", on, O_BRIDGE_ON)
		`CHK("ch1", e1, {O_CH1_NEG, O_CH1_MAG})
		`CHK("ch2", e2, {O_CH2_NEG, O_CH2_MAG})
	endtask

	task wrap_up;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge I_CLK);
		I_SRST <= 1'b0;
		rd(REG_STATUS);
		`CHK("status", 32'h0, rdat)
		rd(8'h10);
		`CHK("unmapped", 32'h0, rdat)
		chk_drv(1'b0, 1'b0);
		`CHK("standby", 1'b1, O_STANDBY)
		wr(REG_CTRL, 32'h1F);
		wait_idle();
		`CHK("woke", 1'b1, seen_wake)
		rd(REG_STATUS);
		`CHK("status", 32'h12, rdat)
		chk_drv(1'b1, 1'b0);
		for (int m = 0; m < 4; m++) begin
			wr(REG_CTRL, 32'h7 | (m << 3));
			wr(REG_STEPS, 32'h1);
			wait_idle();
			pos = pos + incs[m];
			chk_drv(1'b1, m == 0);
		end
		// Two steps downwards check direction and the step count together.
		wr(REG_CTRL, 32'h13);
		wr(REG_STEPS, 32'h2);
		wait_idle();
		pos = pos - 6'h4;
		chk_drv(1'b1, 1'b0);
		wr(REG_CTRL, 32'h19);
		wr(REG_STEPS, 32'h1);
		wait_idle();
		chk_drv(1'b0, 1'b0);
		wr(REG_CTRL, 32'h1B);
		repeat (10) @(negedge I_CLK);
		wr(REG_RESET, 32'h1);
		repeat (6) @(negedge I_CLK);
		pos = 6'h00;
		`CHK("standby", 1'b1, O_STANDBY)
		chk_drv(1'b0, 1'b0);
		wait_idle();
		chk_drv(1'b1, 1'b0);
		wr(REG_CTRL, 32'h0);
		repeat (6) @(negedge I_CLK);
		`CHK("standby", 1'b1, O_STANDBY)
		chk_drv(1'b0, 1'b0);
		wrap_up();
	end
endmodule // strs_tb_top
`default_nettype wire
